/* File: dma_channel_ctrl_status_tb_top.sv */
`timescale 1ns/1ps
`include "dmacs_cfg.svh"
module dma_channel_ctrl_status_tb_top;
    logic core_clk;
    logic reset_n;
    logic clk_en;
    logic [31:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_we;
    logic reg_re;
    logic [31:0] reg_rdata;
    dmacs_pkg::dmacs_engine_t engine_in;
    logic [15:0] chan_run;
    logic [15:0] chan_direct_mode;
    logic [15:0] chan_irq;
    logic irq;
    int error_cnt;
    int check_count;
    logic [31:0] v;
    logic [31:0] ch1;
    logic [31:0] ch2;

    dmacs_ctrl dut (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_we(reg_we),
        .reg_re(reg_re),
        .reg_rdata(reg_rdata),
        .engine_in(engine_in),
        .chan_run(chan_run),
        .chan_direct_mode(chan_direct_mode),
        .chan_irq(chan_irq),
        .irq(irq)
    );

    // ========================================
    // Bus tasks and checks
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_we <= 1'b0;
        #1;
    endtask : wr

    // Read data only stands in the cycle after the strobe, so sample there
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_re <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic wait_clk(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_clk

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Engine inputs lag two flops, so allow settling before looking
    task automatic pulse_evt(input logic [15:0] m, input int k);
        @(posedge core_clk);
        case (k)
            0: engine_in.bus_fault <= m;
            1: engine_in.desc_loaded <= m;
            default: engine_in.xfer_done <= m;
        endcase
        @(posedge core_clk);
        engine_in.bus_fault <= 16'h0000;
        engine_in.desc_loaded <= 16'h0000;
        engine_in.xfer_done <= 16'h0000;
        wait_clk(4);
    endtask : pulse_evt

    task automatic complete_run;
        if (error_cnt == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    // ========================================
    // Clock and watchdog
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    initial
    begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        complete_run();
    end

    // ========================================
    // Scenarios
    initial
    begin
        error_cnt = 0;
        check_count = 0;
        reset_n = 1'b0;
        clk_en = 1'b1;
        reg_addr = 32'h0000_0000;
        reg_wdata = 32'h0000_0000;
        reg_we = 1'b0;
        reg_re = 1'b0;
        engine_in = '0;
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            rd(`DMACS_BASE_ADDR + 32'(4 * i), v);
            chk(v, 32'h0000_0008);
        end
        rd(32'h4000_0048, v);
        chk(v, 32'h0000_0000);
        chk(32'(chan_run), 32'h0000_0000);
        // A write while the core is frozen must be lost
        @(posedge core_clk);
        clk_en <= 1'b0;
        wr(`DMACS_BASE_ADDR + 32'h0000_000c, 32'h8000_0000);
        @(posedge core_clk);
        clk_en <= 1'b1;
        rd(`DMACS_BASE_ADDR + 32'h0000_000c, v);
        chk(v, 32'h0000_0008);
        chk(32'(chan_run[3]), 32'h0000_0000);
        // Enable set before any start counts as a stop interrupt
        wr(`DMACS_BASE_ADDR, 32'h2000_0000);
        wait_clk(2);
        chk(32'(chan_irq[0]), 32'h0000_0001);
        chk(32'(irq), 32'h0000_0000);
        wr(`DMACS_INT_MASK_ADDR, 32'h0000_0001);
        wait_clk(2);
        chk(32'(irq), 32'h0000_0001);
        rd(`DMACS_INT_STATUS_ADDR, v);
        chk(v, 32'h0000_0001);
        rd(`DMACS_INT_MASK_ADDR, v);
        chk(v, 32'h0000_0001);
        wr(`DMACS_BASE_ADDR, 32'h0000_0000);
        wait_clk(2);
        chk(32'(chan_irq[0]), 32'h0000_0000);
        wr(`DMACS_INT_STATUS_ADDR, 32'h0000_0001);
        wait_clk(2);
        chk(32'(irq), 32'h0000_0000);
        ch1 = `DMACS_BASE_ADDR + 32'h0000_0004;
        // Channel 0 runs and drains beside channel 1 so its checks see traffic
        wr(`DMACS_BASE_ADDR, 32'h8000_0000);
        wr(ch1, 32'hc000_0000);
        wait_clk(2);
        chk(32'(chan_run[1:0]), 32'h0000_0003);
        chk(32'(chan_direct_mode[1]), 32'h0000_0001);
        @(posedge core_clk);
        engine_in.request[1] <= 1'b1;
        engine_in.burst_active[1:0] <= 2'b11;
        wait_clk(4);
        rd(ch1, v);
        chk(v, 32'hc000_0100);
        wr(`DMACS_BASE_ADDR, 32'h0000_0000);
        wr(ch1, 32'h4000_0000);
        wait_clk(6);
        // Draining: no longer running, yet not halted until the burst ends
        chk(32'(chan_run[1:0]), 32'h0000_0000);
        rd(ch1, v);
        chk(v, 32'h4000_0100);
        rd(`DMACS_BASE_ADDR, v);
        chk(v, 32'h0000_0000);
        @(posedge core_clk);
        engine_in.request[1] <= 1'b0;
        engine_in.burst_active[1:0] <= 2'b00;
        engine_in.burst_done[1:0] <= 2'b11;
        @(posedge core_clk);
        engine_in.burst_done[1:0] <= 2'b00;
        v = 32'h0000_0000;
        for (int t = 0; t < 12 && v[`DMACS_HALT_BIT] !== 1'b1; t++)
            rd(ch1, v);
        chk(32'(v[`DMACS_HALT_BIT]), 32'h0000_0001);
        chk(32'(chan_run[1]), 32'h0000_0000);
        wait_clk(4);
        rd(ch1, v);
        chk(v, 32'h4000_0008);
        chk(32'(chan_irq[1]), 32'h0000_0000);
        chk(32'(chan_run[1]), 32'h0000_0000);
        wr(ch1, 32'h8000_0000);
        wait_clk(2);
        chk(32'(chan_run[1]), 32'h0000_0001);
        chk(32'(chan_direct_mode[1]), 32'h0000_0000);
        // Each event source on its own, then cleared by write-back; channel 0 shares the pulse
        ch2 = `DMACS_BASE_ADDR + 32'h0000_0008;
        for (int k = 0; k < 3; k++)
        begin
            pulse_evt(16'h0005, k);
            chk(32'(chan_irq[2]), 32'h0000_0001);
            wr(ch2, 32'h0000_0000);
            rd(ch2, v);
            chk(v, 32'h0000_0008 | (32'h1 << k));
            wr(ch2, v);
            wait_clk(2);
            rd(ch2, v);
            chk(v, 32'h0000_0008);
            chk(32'(chan_irq[2]), 32'h0000_0000);
        end
        complete_run();
    end
endmodule : dma_channel_ctrl_status_tb_top

/* File: dmacs_cfg.svh */
`ifndef DMACS_CFG_SVH
`define DMACS_CFG_SVH
// Register map: sixteen channel words from the base
`define DMACS_BASE_ADDR 32'h4000_0000
`define DMACS_LAST_ADDR 32'h4000_003c
`define DMACS_INT_STATUS_ADDR 32'h4000_0040
`define DMACS_INT_MASK_ADDR 32'h4000_0044
`define DMACS_NUM_CH 16
// Field positions
`define DMACS_RUN_BIT 31
`define DMACS_DIRECT_BIT 30
`define DMACS_HIEN_BIT 29
`define DMACS_REQ_BIT 8
`define DMACS_HALT_BIT 3
`define DMACS_DONE_BIT 2
`define DMACS_LOAD_BIT 1
`define DMACS_FAULT_BIT 0
// Reset values
`define DMACS_CSR_RESET 32'h0000_0008
`define DMACS_MASK_RESET 16'h0000
`endif

/* File: dmacs_chan_mem.sv */
`timescale 1ns/1ps
`include "dmacs_cfg.svh"
// Channel register store; one entry per channel, every entry driven straight out on ch with no read register
module dmacs_chan_mem (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire dmacs_pkg::dmacs_ch_t next_ch [`DMACS_NUM_CH],
    output dmacs_pkg::dmacs_ch_t ch [`DMACS_NUM_CH]
);
    dmacs_pkg::dmacs_ch_t mem [`DMACS_NUM_CH];

    always_ff @(posedge core_clk)
    begin
        for (int i = 0; i < `DMACS_NUM_CH; i++)
        begin
            if (!reset_n)
            begin
                mem[i] <= '{run: 1'b0, direct_register_mode: 1'b0, halt_irq_enable: 1'b0,
                            halted_flag: 1'b1, completion_irq_flag: 1'b0, load_irq_flag: 1'b0,
                            bus_fault_irq_flag: 1'b0, state: dmacs_pkg::DMACS_HALTED};
            end
            else if (clk_en)
            begin
                mem[i] <= next_ch[i];
            end
        end
    end

    assign ch = mem;
endmodule : dmacs_chan_mem

/* File: dmacs_ctrl.sv */
`timescale 1ns/1ps
`include "dmacs_cfg.svh"
module dmacs_ctrl (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [31:0] reg_rdata,
    input wire dmacs_pkg::dmacs_engine_t engine_in,
    output logic [15:0] chan_run,
    output logic [15:0] chan_direct_mode,
    output logic [15:0] chan_irq,
    output logic irq
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [31:0] rdata;
        logic [15:0] run_o;
        logic [15:0] direct_o;
        logic [15:0] chirq;
        logic irq;
        logic [15:0] int_status;
        logic [15:0] int_mask;
        dmacs_pkg::dmacs_engine_t sync1;
        dmacs_pkg::dmacs_engine_t sync2;
    } dmacs_top_t;

    dmacs_top_t st;
    dmacs_top_t next_st;
    dmacs_pkg::dmacs_ch_t ch [`DMACS_NUM_CH];
    dmacs_pkg::dmacs_ch_t next_ch [`DMACS_NUM_CH];

    dmacs_chan_mem u_mem (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .next_ch(next_ch),
        .ch(ch)
    );

    // ==========================================================
    // Helpers
    function automatic logic dmacs_is_chan(input logic [31:0] a);
        return (a >= `DMACS_BASE_ADDR) && (a <= `DMACS_LAST_ADDR) && (a[1:0] == 2'b00);
    endfunction : dmacs_is_chan

    function automatic logic [3:0] dmacs_chan_idx(input logic [31:0] a);
        return a[5:2];
    endfunction : dmacs_chan_idx

    function automatic logic dmacs_ch_irq(input dmacs_pkg::dmacs_ch_t c);
        return (c.halt_irq_enable & c.halted_flag) | c.completion_irq_flag
            | c.load_irq_flag | c.bus_fault_irq_flag;
    endfunction : dmacs_ch_irq

    function automatic logic [31:0] dmacs_pack(input dmacs_pkg::dmacs_ch_t c, input logic req);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[`DMACS_RUN_BIT] = c.run;
        v[`DMACS_DIRECT_BIT] = c.direct_register_mode;
        v[`DMACS_HIEN_BIT] = c.halt_irq_enable;
        v[`DMACS_REQ_BIT] = req;
        v[`DMACS_HALT_BIT] = c.halted_flag;
        v[`DMACS_DONE_BIT] = c.completion_irq_flag;
        v[`DMACS_LOAD_BIT] = c.load_irq_flag;
        v[`DMACS_FAULT_BIT] = c.bus_fault_irq_flag;
        return v;
    endfunction : dmacs_pack

    // ==========================================================
    // Next state
    always_comb
    begin
        logic wr_ch;
        logic [3:0] idx;
        logic [15:0] irq_vec;
        logic [15:0] clr;
        wr_ch = reg_we && dmacs_is_chan(reg_addr);
        idx = dmacs_chan_idx(reg_addr);
        irq_vec = 16'h0000;
        clr = 16'h0000;
        next_st = st;
        next_st.sync1 = engine_in;
        next_st.sync2 = st.sync1;
        for (int i = 0; i < `DMACS_NUM_CH; i++)
        begin
            logic hit;
            logic busy;
            hit = wr_ch && (idx == 4'(i));
            busy = st.sync2.burst_active[i] && !st.sync2.burst_done[i];
            next_ch[i] = ch[i];
            if (hit)
            begin
                next_ch[i].run = reg_wdata[`DMACS_RUN_BIT];
                next_ch[i].direct_register_mode = reg_wdata[`DMACS_DIRECT_BIT];
                next_ch[i].halt_irq_enable = reg_wdata[`DMACS_HIEN_BIT];
                // Write-one-to-clear; events in the same cycle win below
                if (reg_wdata[`DMACS_DONE_BIT])
                begin
                    next_ch[i].completion_irq_flag = 1'b0;
                end
                if (reg_wdata[`DMACS_LOAD_BIT])
                begin
                    next_ch[i].load_irq_flag = 1'b0;
                end
                if (reg_wdata[`DMACS_FAULT_BIT])
                begin
                    next_ch[i].bus_fault_irq_flag = 1'b0;
                end
            end
            if (st.sync2.xfer_done[i])
            begin
                next_ch[i].completion_irq_flag = 1'b1;
            end
            if (st.sync2.desc_loaded[i])
            begin
                next_ch[i].load_irq_flag = 1'b1;
            end
            if (st.sync2.bus_fault[i])
            begin
                next_ch[i].bus_fault_irq_flag = 1'b1;
            end
            case (ch[i].state)
                dmacs_pkg::DMACS_HALTED:
                begin
                    next_ch[i].halted_flag = 1'b1;
                    if (hit && reg_wdata[`DMACS_RUN_BIT])
                    begin
                        next_ch[i].state = dmacs_pkg::DMACS_RUNNING;
                        next_ch[i].halted_flag = 1'b0;
                    end
                end
                dmacs_pkg::DMACS_RUNNING:
                begin
                    if (!next_ch[i].run)
                    begin
                        // Never cut a burst short: the bus would be left mid-transfer
                        next_ch[i].state = busy ? dmacs_pkg::DMACS_DRAINING : dmacs_pkg::DMACS_HALTED;
                        next_ch[i].halted_flag = !busy;
                    end
                end
                dmacs_pkg::DMACS_DRAINING:
                begin
                    if (!busy)
                    begin
                        next_ch[i].state = dmacs_pkg::DMACS_HALTED;
                        next_ch[i].halted_flag = 1'b1;
                    end
                end
                default:
                begin
                    next_ch[i].state = dmacs_pkg::DMACS_HALTED;
                end
            endcase
            irq_vec[i] = dmacs_ch_irq(next_ch[i]);
            next_st.run_o[i] = next_ch[i].run && !next_ch[i].halted_flag;
            next_st.direct_o[i] = next_ch[i].direct_register_mode;
        end
        next_st.chirq = irq_vec;
        // Sticky summary status, set wins over a clear
        if (reg_we && (reg_addr == `DMACS_INT_STATUS_ADDR))
        begin
            clr = reg_wdata[15:0];
        end
        next_st.int_status = (st.int_status & ~clr) | irq_vec;
        if (reg_we && (reg_addr == `DMACS_INT_MASK_ADDR))
        begin
            next_st.int_mask = reg_wdata[15:0];
        end
        next_st.irq = |(next_st.int_status & next_st.int_mask);
        next_st.rdata = 32'h0000_0000;
        if (reg_re)
        begin
            if (dmacs_is_chan(reg_addr))
            begin
                next_st.rdata = dmacs_pack(ch[idx], st.sync2.request[idx]);
            end
            else if (reg_addr == `DMACS_INT_STATUS_ADDR)
            begin
                next_st.rdata = {16'h0000, st.int_status};
            end
            else if (reg_addr == `DMACS_INT_MASK_ADDR)
            begin
                next_st.rdata = {16'h0000, st.int_mask};
            end
            else
            begin
                next_st.rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            st <= '0;
        end
        else if (clk_en)
        begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign chan_run = st.run_o;
    assign chan_direct_mode = st.direct_o;
    assign chan_irq = st.chirq;
    assign irq = st.irq;

    // ==========================================================
    // Checks
    property p_halt_irq;
        @(posedge core_clk) disable iff (!reset_n)
        clk_en && $past(clk_en) && ch[0].halt_irq_enable && ch[0].halted_flag |-> chan_irq[0];
    endproperty
    a_halt_irq: assert property (p_halt_irq) else $error("halt irq missing");

    property p_no_irq_quiet;
        @(posedge core_clk) disable iff (!reset_n)
        clk_en && !ch[0].halt_irq_enable && !ch[0].completion_irq_flag && !ch[0].load_irq_flag
            && !ch[0].bus_fault_irq_flag |-> !chan_irq[0];
    endproperty
    a_no_irq_quiet: assert property (p_no_irq_quiet) else $error("spurious irq");

    sequence s_start;
        clk_en && reg_we && reg_addr == `DMACS_BASE_ADDR && reg_wdata[`DMACS_RUN_BIT] && ch[0].halted_flag;
    endsequence
    property p_start;
        @(posedge core_clk) disable iff (!reset_n)
        s_start |=> !clk_en || (!ch[0].halted_flag && ch[0].run);
    endproperty
    a_start: assert property (p_start) else $error("run write did not start");

    property p_resume;
        @(posedge core_clk) disable iff (!reset_n)
        clk_en && ch[0].halted_flag && !(reg_we && reg_addr == `DMACS_BASE_ADDR) |=> ch[0].halted_flag;
    endproperty
    a_resume: assert property (p_resume) else $error("halted channel resumed alone");

    property p_drain;
        @(posedge core_clk) disable iff (!reset_n)
        clk_en && ch[0].state == dmacs_pkg::DMACS_DRAINING && st.sync2.burst_active[0]
            && !st.sync2.burst_done[0] |=> !ch[0].halted_flag;
    endproperty
    a_drain: assert property (p_drain) else $error("halted mid burst");

    property p_fault_set;
        @(posedge core_clk) disable iff (!reset_n)
        clk_en && st.sync2.bus_fault[0] |=> ch[0].bus_fault_irq_flag;
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault flag not set");

    property p_flag_hold;
        @(posedge core_clk) disable iff (!reset_n)
        ch[0].completion_irq_flag && !(reg_we && reg_addr == `DMACS_BASE_ADDR
            && reg_wdata[`DMACS_DONE_BIT]) |=> ch[0].completion_irq_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag cleared without write");

    property p_read;
        @(posedge core_clk) disable iff (!reset_n)
        clk_en && reg_re && reg_addr == `DMACS_BASE_ADDR |=> !clk_en
            || (reg_rdata[`DMACS_HALT_BIT] == $past(ch[0].halted_flag) && reg_rdata[28:9] == 20'h00000);
    endproperty
    a_read: assert property (p_read) else $error("channel read wrong");
endmodule : dmacs_ctrl

/* File: dmacs_pkg.sv */
package dmacs_pkg;
    typedef enum logic [1:0] {
        DMACS_HALTED,
        DMACS_RUNNING,
        DMACS_DRAINING
    } dmacs_state_t;

    typedef struct packed {
        logic run;
        logic direct_register_mode;
        logic halt_irq_enable;
        logic halted_flag;
        logic completion_irq_flag;
        logic load_irq_flag;
        logic bus_fault_irq_flag;
        dmacs_state_t state;
    } dmacs_ch_t;

    typedef struct packed {
        logic [15:0] burst_active;
        logic [15:0] burst_done;
        logic [15:0] xfer_done;
        logic [15:0] desc_loaded;
        logic [15:0] bus_fault;
        logic [15:0] request;
    } dmacs_engine_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic we;
    } dmacs_wr_t;
endpackage : dmacs_pkg
